/* File: common/ovh_map.svh */
`ifndef OVH_MAP_SVH
`define OVH_MAP_SVH

// Register offsets.
`define OVH_DLS_OFFSET      8'h0A
`define OVH_FRM_OFFSET      8'h0B
`define OVH_STAT_OFFSET     8'h0C

// Field positions inside the data link select register.
`define OVH_SRC_LSB         0
`define OVH_BW_LSB          4

// Reset values.
`define OVH_DLS_RESET       8'h00
`define OVH_FRM_RESET       2'h0

// Frames in one extended superframe, counted from zero.
`define OVH_LAST_FRAME      5'h17

// Strobe high time and the transmit clock period it is counted in.
`define OVH_STROBE_NS       300
`define OVH_TXCLK_NS        30
`define OVH_STROBE_CYCLES   ((`OVH_STROBE_NS + `OVH_TXCLK_NS - 1) / `OVH_TXCLK_NS)

`endif

/* File: common/ovh_pkg.sv */
`default_nettype none

package ovh_pkg;

    typedef enum logic [1:0] {
        SRC_HDLC    = 2'b00,
        SRC_PAYLOAD = 2'b01,
        SRC_OVH     = 2'b10,
        SRC_ONES    = 2'b11
    } dl_source_e;

    typedef enum logic [1:0] {
        BW_4K       = 2'b00,
        BW_2K_ODD   = 2'b01,
        BW_2K_EVEN  = 2'b10,
        BW_RESERVED = 2'b11
    } dl_bw_e;

    typedef enum logic [1:0] {
        MODE_ESF    = 2'b00,
        MODE_SF_SIG = 2'b01,
        MODE_N      = 2'b10,
        MODE_DDM    = 2'b11
    } frame_mode_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    typedef struct packed {
        logic [7:0] dls;
        logic [1:0] frm;
        logic       req;
        logic       cap_s1;
        logic       cap_s2;
        logic       stb_s1;
        logic       stb_s2;
        logic [7:0] rdata;
        logic [7:0] dls_x;
        logic [1:0] frm_x;
        logic       dirty;
        logic       ack_s1;
        logic       ack_s2;
    } sys_state_s;

    typedef struct packed {
        logic        req_s1;
        logic        req_s2;
        logic        req_s3;
        dl_source_e  src;
        dl_bw_e      bw;
        frame_mode_e mode;
        logic [4:0]  frame_idx;
        logic        strobe;
        logic [7:0]  cnt;
        logic        captured;
        logic        data_s1;
        logic        data_s2;
        logic        dl_bit;
        logic        dl_valid;
    } tx_state_s;

endpackage

`default_nettype wire

/* File: hdl/ovh_tx_port.sv */
// Contract
// - Each channel has a strobe output and a serial data input.
// - One rising strobe edge for every data link bit position.
// - Serial data is captured on each falling strobe edge.
// - Captured bits go into the data link positions of outgoing frames.
// - Source 00 takes bits from the link-layer controller.
// - Source 01 takes bits from the payload serial input.
// - Source 10 takes bits from the overhead input port only.
// - Source 11 forces every data link bit to one.
// - Bandwidth 00 in ESF uses every facility link bit, 4 kHz.
// - Bandwidth 01 uses odd facility bits, frames 1, 5, 9.
// - Bandwidth 10 uses even facility bits, frames 3, 7, 11.
// - In signaling framing modes the same source field selects the bits.
// - In digital data mode the source governs the timeslot 24 bit.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ovh_map.svh"

module ovh_tx_port
#(
    parameter int STROBE_CYCLES = `OVH_STROBE_CYCLES
)
(
    input  wire logic             CLK_SYS,
    input  wire logic             SYS_RST,
    input  wire ovh_pkg::reg_req_s REG_REQ,
    output logic [7:0]            RDATA,
    input  wire logic             TX_CLK,
    input  wire logic             TX_FRAME_SYNC,
    input  wire logic             TX_FRAME_START,
    input  wire logic             TX_OVH_SLOT,
    input  wire logic             HDLC_BIT,
    input  wire logic             TX_PAYLOAD_SERIAL_IN,
    output logic                  OVH_IN_STROBE_OUT,
    input  wire logic             OVH_IN_SERIAL_DATA,
    output logic                  DL_BIT,
    output logic                  DL_VALID
);
    import ovh_pkg::*;

    localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYCLES - 1);

    sys_state_s sys_q;
    sys_state_s next_sys;
    tx_state_s  tx_q;
    tx_state_s  next_tx;
    logic       tx_rst_s1;
    logic       tx_rst;
    logic       position;

    // Tells whether the overhead slot of this frame carries a data link bit.
    function automatic logic dl_position(input frame_mode_e mode,
                                         input dl_bw_e      bw,
                                         input logic [4:0]  idx);
        logic used;
        used = 1'b0;
        case (mode)
            MODE_ESF:
            begin
                case (bw)
                    BW_2K_ODD:  used = (idx[1:0] == 2'h0);
                    BW_2K_EVEN: used = (idx[1:0] == 2'h2);
                    default:    used = ~idx[0];
                endcase
            end
            MODE_SF_SIG: used = idx[0];
            MODE_N:      used = idx[0];
            MODE_DDM:    used = 1'b1;
            default:     used = 1'b0;
        endcase
        return used;
    endfunction

    // Register side: configuration, change request toggle and status view.
    always_comb
    begin
        next_sys        = sys_q;
        next_sys.cap_s1 = tx_q.captured;
        next_sys.cap_s2 = sys_q.cap_s1;
        next_sys.stb_s1 = tx_q.strobe;
        next_sys.stb_s2 = sys_q.stb_s1;
        next_sys.rdata  = 8'h00;
        next_sys.ack_s1 = tx_q.req_s3;
        next_sys.ack_s2 = sys_q.ack_s1;
        // A new settings copy is launched only after the last one was seen.
        if (sys_q.dirty && (sys_q.ack_s2 == sys_q.req))
        begin
            next_sys.dls_x = sys_q.dls;
            next_sys.frm_x = sys_q.frm;
            next_sys.req   = ~sys_q.req;
            next_sys.dirty = 1'b0;
        end
        if (REG_REQ.wr)
        begin
            case (REG_REQ.addr)
                `OVH_DLS_OFFSET:
                begin
                    next_sys.dls   = REG_REQ.wdata & 8'h33;
                    next_sys.dirty = 1'b1;
                end
                `OVH_FRM_OFFSET:
                begin
                    next_sys.frm   = REG_REQ.wdata[1:0];
                    next_sys.dirty = 1'b1;
                end
                default: next_sys.dirty = sys_q.dirty;
            endcase
        end
        if (REG_REQ.rd)
        begin
            case (REG_REQ.addr)
                `OVH_DLS_OFFSET:  next_sys.rdata = sys_q.dls;
                `OVH_FRM_OFFSET:  next_sys.rdata = {6'h00, sys_q.frm};
                `OVH_STAT_OFFSET:
                    next_sys.rdata = {6'h00, sys_q.stb_s2, sys_q.cap_s2};
                default:          next_sys.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            sys_q     <= '0;
            sys_q.dls <= `OVH_DLS_RESET;
            sys_q.frm <= `OVH_FRM_RESET;
            sys_q.dls_x <= `OVH_DLS_RESET;
            sys_q.frm_x <= `OVH_FRM_RESET;
        end
        else
        begin
            sys_q <= next_sys;
        end
    end

    assign RDATA = sys_q.rdata;

    // Reset for the transmit domain, released on its own clock.
    always_ff @(posedge TX_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            tx_rst_s1 <= 1'b1;
            tx_rst    <= 1'b1;
        end
        else
        begin
            tx_rst_s1 <= 1'b0;
            tx_rst    <= tx_rst_s1;
        end
    end

    assign position = TX_OVH_SLOT && dl_position(tx_q.mode, tx_q.bw,
                                                 tx_q.frame_idx);

    // Transmit side: frame count, strobe generation, capture and insertion.
    always_comb
    begin
        next_tx          = tx_q;
        next_tx.req_s1   = sys_q.req;
        next_tx.req_s2   = tx_q.req_s1;
        next_tx.req_s3   = tx_q.req_s2;
        next_tx.data_s1  = OVH_IN_SERIAL_DATA;
        next_tx.data_s2  = tx_q.data_s1;
        next_tx.dl_valid = 1'b0;
        // The settings copy is stable once the request toggle has crossed.
        if (tx_q.req_s2 != tx_q.req_s3)
        begin
            next_tx.src  = dl_source_e'(sys_q.dls_x[`OVH_SRC_LSB +: 2]);
            next_tx.bw   = dl_bw_e'(sys_q.dls_x[`OVH_BW_LSB +: 2]);
            next_tx.mode = frame_mode_e'(sys_q.frm_x);
        end
        if (TX_FRAME_SYNC)
        begin
            next_tx.frame_idx = 5'h00;
        end
        else if (TX_FRAME_START)
        begin
            if (tx_q.frame_idx == `OVH_LAST_FRAME)
            begin
                next_tx.frame_idx = 5'h00;
            end
            else
            begin
                next_tx.frame_idx = tx_q.frame_idx + 5'h01;
            end
        end
        if (tx_q.strobe)
        begin
            if (tx_q.cnt == 8'h00)
            begin
                next_tx.strobe   = 1'b0;
                next_tx.captured = tx_q.data_s2;
            end
            else
            begin
                next_tx.cnt = tx_q.cnt - 8'h01;
            end
        end
        if (position)
        begin
            next_tx.strobe   = 1'b1;
            next_tx.cnt      = STROBE_LAST;
            next_tx.dl_valid = 1'b1;
            case (tx_q.src)
                SRC_HDLC:    next_tx.dl_bit = HDLC_BIT;
                SRC_PAYLOAD: next_tx.dl_bit = TX_PAYLOAD_SERIAL_IN;
                SRC_OVH:     next_tx.dl_bit = tx_q.captured;
                SRC_ONES:    next_tx.dl_bit = 1'b1;
                default:     next_tx.dl_bit = 1'b1;
            endcase
        end
    end

    always_ff @(posedge TX_CLK or posedge tx_rst)
    begin
        if (tx_rst)
        begin
            tx_q          <= '0;
            tx_q.captured <= 1'b1;
            tx_q.dl_bit   <= 1'b1;
        end
        else
        begin
            tx_q <= next_tx;
        end
    end

    assign OVH_IN_STROBE_OUT = tx_q.strobe;
    assign DL_BIT            = tx_q.dl_bit;
    assign DL_VALID          = tx_q.dl_valid;

    sequence strobe_start;
        !tx_q.strobe ##1 tx_q.strobe;
    endsequence

    sequence strobe_held;
        tx_q.strobe [*4];
    endsequence

    strobe_rise_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        position && !tx_q.strobe |-> strobe_start ##0 strobe_held)
        else $error("Strobe did not rise for a data link position.");

    strobe_only_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        $rose(tx_q.strobe) |-> $past(position))
        else $error("Strobe rose without a data link position.");

    capture_fall_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        $fell(tx_q.strobe) |-> tx_q.captured == $past(tx_q.data_s2))
        else $error("Serial data not captured at strobe fall.");

    insert_ovh_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        position && tx_q.src == SRC_OVH
            |=> DL_VALID && DL_BIT == $past(tx_q.captured))
        else $error("Overhead bit not inserted.");

    force_ones_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        position && tx_q.src == SRC_ONES |=> DL_VALID && DL_BIT)
        else $error("Data link bit not forced to one.");

    link_source_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        position && tx_q.src == SRC_HDLC |=> DL_BIT == $past(HDLC_BIT))
        else $error("Controller bit not inserted.");

    payload_source_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        position && tx_q.src == SRC_PAYLOAD
            |=> DL_BIT == $past(TX_PAYLOAD_SERIAL_IN))
        else $error("Payload bit not inserted.");

    valid_slot_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        DL_VALID |-> $past(TX_OVH_SLOT))
        else $error("Data link bit outside an overhead slot.");

    odd_frames_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        DL_VALID && $past(tx_q.mode == MODE_ESF && tx_q.bw == BW_2K_ODD)
            |-> $past(tx_q.frame_idx[1:0]) == 2'h0)
        else $error("Odd bandwidth used a wrong frame.");

    even_frames_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        DL_VALID && $past(tx_q.mode == MODE_ESF && tx_q.bw == BW_2K_EVEN)
            |-> $past(tx_q.frame_idx[1:0]) == 2'h2)
        else $error("Even bandwidth used a wrong frame.");

    full_rate_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        TX_OVH_SLOT && tx_q.mode == MODE_ESF && !tx_q.frame_idx[0]
            && (tx_q.bw == BW_4K || tx_q.bw == BW_RESERVED)
            |=> DL_VALID)
        else $error("Full rate skipped a facility bit.");

    ddm_every_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        TX_OVH_SLOT && tx_q.mode == MODE_DDM |=> DL_VALID)
        else $error("Digital data mode skipped a frame.");

    sig_frames_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        DL_VALID && $past(tx_q.mode == MODE_SF_SIG || tx_q.mode == MODE_N)
            |-> $past(tx_q.frame_idx[0]))
        else $error("Signaling framing bit in a wrong frame.");

    bit_hold_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        !position |=> !DL_VALID && DL_BIT == $past(DL_BIT))
        else $error("Data link bit changed outside a position.");

    strobe_keep_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        tx_q.strobe && tx_q.cnt != 8'h00 |=> tx_q.strobe)
        else $error("Strobe fell before its count ran out.");

    sync_index_a: assert property (
        @(posedge TX_CLK) disable iff (tx_rst)
        TX_FRAME_SYNC |=> tx_q.frame_idx == 5'h00)
        else $error("Frame sync did not restart the frame count.");

    select_read_a: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        REG_REQ.rd && REG_REQ.addr == `OVH_DLS_OFFSET
            |=> RDATA == $past(sys_q.dls))
        else $error("Select register read back a wrong value.");

    read_idle_a: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !REG_REQ.rd |=> RDATA == 8'h00)
        else $error("Read data stood outside a read.");

endmodule
`default_nettype wire

/* File: test/ovh_far_end.sv */
`timescale 1ns/1ps
`default_nettype none

module ovh_far_end
#(
    parameter logic [31:0] PAT = 32'hC3A5_96E1
)
(
    input  wire logic strobe,
    output logic      data
);
    int   idx = 0;
    logic bit_q = 1'b1;

    assign data = bit_q;

    // Presents the next pattern bit shortly after each rising strobe edge.
    always @(posedge strobe)
    begin
        bit_q <= #2 PAT[idx % 32];
        idx = idx + 1;
    end
endmodule

`default_nettype wire

/* File: test/ovh_tx_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ovh_map.svh"

module ovh_tx_port_bench;
    import ovh_pkg::*;
    localparam logic [31:0] PAT = 32'hC3A5_96E1;
    logic       clk_sys = 1'b0;
    logic       tx_clk = 1'b0;
    logic       sys_rst = 1'b1;
    reg_req_s   req = '0;
    logic [7:0] rdata;
    logic       sync = 1'b0;
    logic       start = 1'b0;
    logic       slot = 1'b0;
    logic       hdlc = 1'b0;
    logic       pay = 1'b0;
    logic       strobe;
    logic       ser;
    logic       dl_bit;
    logic       dl_valid;
    int         fails = 0;
    int         tests_run = 0;
    int         rises = 0;

    initial forever #5 clk_sys = ~clk_sys;
    initial #7 forever #15 tx_clk = ~tx_clk;
    always @(posedge strobe) rises++;

    ovh_tx_port #(.STROBE_CYCLES(5)) dut (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_REQ(req),
        .RDATA(rdata), .TX_CLK(tx_clk), .TX_FRAME_SYNC(sync),
        .TX_FRAME_START(start), .TX_OVH_SLOT(slot), .HDLC_BIT(hdlc),
        .TX_PAYLOAD_SERIAL_IN(pay), .OVH_IN_STROBE_OUT(strobe),
        .OVH_IN_SERIAL_DATA(ser), .DL_BIT(dl_bit), .DL_VALID(dl_valid)
    );

    ovh_far_end #(.PAT(PAT)) far (.strobe(strobe), .data(ser));

    task automatic results();
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req <= '0;
        #1 chk("rdata", exp, rdata);
    endtask

    task automatic regs();
        rd(`OVH_DLS_OFFSET, `OVH_DLS_RESET);
        rd(`OVH_FRM_OFFSET, 8'h00);
        wr(`OVH_FRM_OFFSET, 8'hFF);
        rd(`OVH_FRM_OFFSET, 8'h03);
        wr(`OVH_DLS_OFFSET, 8'hFF);
        rd(`OVH_DLS_OFFSET, 8'h33);
        wr(8'h3F, 8'h55);
        rd(8'h3F, 8'h00);
    endtask

    task automatic status();
        rd(`OVH_STAT_OFFSET, {6'h00, 1'b0, PAT[(rises + 31) % 32]});
    endtask

    task automatic frames(input logic [1:0] mode, bw, src);
        logic       pos;
        logic [7:0] exp;
        int         n;
        int         cnt;
        wr(`OVH_FRM_OFFSET, {6'h00, mode});
        wr(`OVH_DLS_OFFSET, {2'b00, bw, 2'b00, src});
        repeat (12) @(posedge tx_clk);
        n = rises;
        cnt = 0;
        for (int i = 0; i < 24; i++)
        begin
            @(posedge tx_clk);
            sync <= (i == 0);
            start <= 1'b1;
            hdlc <= i[1];
            pay <= i[2];
            @(posedge tx_clk);
            sync <= 1'b0;
            start <= 1'b0;
            slot <= 1'b1;
            @(posedge tx_clk);
            slot <= 1'b0;
            #1;
            pos = (mode == 2'b11) || ((mode != 2'b00) ? (i % 2 == 1) :
                  (bw == 2'b01) ? (i % 4 == 0) :
                  (bw == 2'b10) ? (i % 4 == 2) : (i % 2 == 0));
            exp = (src == 2'b00) ? i[1] : (src == 2'b01) ? i[2] :
                  (src == 2'b11) ? 8'h01 : PAT[(rises + 30) % 32];
            cnt += pos;
            chk("dl_valid", pos, dl_valid);
            if (pos)
                chk("dl_bit", exp, dl_bit);
            repeat (8) @(posedge tx_clk);
        end
        chk("strobe rises", 8'(cnt), 8'(rises - n));
    endtask

    initial
    begin
        #400us;
        fails++;
        results();
    end

    initial
    begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (6) @(posedge tx_clk);
        regs();
        for (int s = 0; s < 4; s++)
            frames(2'b00, 2'b00, s[1:0]);
        for (int b = 1; b < 4; b++)
            frames(2'b00, b[1:0], 2'b10);
        for (int m = 1; m < 4; m++)
            frames(m[1:0], 2'b00, 2'b10);
        status();
        results();
    end
endmodule

`default_nettype wire
